/* File: hdl/fsp_pkg.sv */
// Constants and types shared by the self-programming device and its controller
package fsp_pkg;
    localparam int FSP_CLK_HZ = 50000000;
    localparam int FSP_PROG_MIN_US = 3700;
    localparam int FSP_PROG_MAX_US = 4500;
    // Erase/write duration: midpoint of the allowed window, in cycles
    localparam int FSP_PROG_CYCLES = ((FSP_PROG_MIN_US + FSP_PROG_MAX_US) / 2) * (FSP_CLK_HZ / 1000000);
    localparam int FSP_LOAD_WINDOW = 3;
    localparam int FSP_STORE_WINDOW = 4;
    localparam logic [15:0] FSP_PTR_FUSE_LOW = 16'h0000;
    localparam logic [15:0] FSP_PTR_LOCK = 16'h0001;
    localparam logic [15:0] FSP_PTR_FUSE_EXT = 16'h0002;
    localparam logic [15:0] FSP_PTR_FUSE_HIGH = 16'h0003;
    // Control/status bit positions
    localparam int FSP_BIT_STORE_EN = 0;
    localparam int FSP_BIT_PAGE_ERASE = 1;
    localparam int FSP_BIT_PAGE_WRITE = 2;
    localparam int FSP_BIT_LOCK_ARM = 3;
    localparam int FSP_BIT_RWW_REEN = 4;
    localparam int FSP_BIT_RWW_BUSY = 6;
    localparam logic [7:0] FSP_CMD_ERASE = 8'h03;
    localparam logic [7:0] FSP_CMD_WRITE = 8'h05;
    localparam logic [7:0] FSP_CMD_FILL = 8'h01;
    localparam logic [7:0] FSP_CMD_LOCK_READ = 8'h09;
    localparam logic [7:0] FSP_CMD_REENABLE = 8'h11;
    // Controller Wishbone register offsets
    localparam logic [3:0] FSP_REG_CMD = 4'h0;
    localparam logic [3:0] FSP_REG_PTR = 4'h4;
    localparam logic [3:0] FSP_REG_DATA = 4'h8;
    localparam logic [3:0] FSP_REG_STAT = 4'hc;
    localparam logic [3:0] FSP_REG_IRQ_CLR = 4'h0;
    localparam logic [5:0] FSP_REG_IRQ_EN = 6'h10;
    localparam logic [5:0] FSP_REG_IRQ_ST = 6'h14;
    localparam logic [5:0] FSP_REG_IRQ_CL = 6'h18;
    localparam logic [5:0] FSP_REG_RESULT = 6'h1c;
    localparam logic [5:0] FSP_REG_STATUS = 6'h0c;
    localparam logic [5:0] FSP_REG_COMMAND = 6'h00;
    localparam logic [5:0] FSP_REG_POINTER = 6'h04;
    localparam logic [5:0] FSP_REG_WDATA = 6'h08;
    localparam logic [7:0] FSP_FUSE_LOW_DEF = 8'h62;
    localparam logic [7:0] FSP_FUSE_HIGH_DEF = 8'h99;
    localparam logic [7:0] FSP_FUSE_EXT_DEF = 8'hff;
    localparam logic [7:0] FSP_LOCK_DEF = 8'hff;
    typedef enum logic [2:0] {
        FSP_C_IDLE = 3'b000,
        FSP_C_POLL = 3'b001,
        FSP_C_CTRL = 3'b010,
        FSP_C_OP = 3'b011,
        FSP_C_WAIT = 3'b100
    } fsp_ctl_state_t;
endpackage : fsp_pkg

/* File: hdl/fsp_link_if.sv */
// Link between the self-programming device and the CPU-side controller
`timescale 1ns/1ns
`default_nettype none
interface fsp_link_if;
    logic ctrlWe;
    logic [7:0] ctrlWdata;
    logic [7:0] ctrlRdata;
    logic loadStrobe;
    logic storeStrobe;
    logic [15:0] pointer;
    logic [15:0] storeData;
    logic [7:0] loadData;
    logic loadValid;
    logic eepromWriteBusyFlag;
    logic cpuHalt;
    logic nrwwReadOnly;
    modport device (
        input ctrlWe, ctrlWdata, loadStrobe, storeStrobe, pointer, storeData,
        output ctrlRdata, loadData, loadValid, eepromWriteBusyFlag, cpuHalt, nrwwReadOnly
    );
    modport host (
        output ctrlWe, ctrlWdata, loadStrobe, storeStrobe, pointer, storeData,
        input ctrlRdata, loadData, loadValid, eepromWriteBusyFlag, cpuHalt, nrwwReadOnly
    );
endinterface : fsp_link_if
`default_nettype wire

/* File: hdl/fsp_device.sv */
// Self-programming device: control/status register, timed flash ops, fuse and lock readback
`timescale 1ns/1ns
`default_nettype none
module fsp_device
    import fsp_pkg::*;
#(
    parameter int PROG_CYCLES = FSP_PROG_CYCLES,
    parameter int WORDS = 64
) (
    input wire logic clk,
    input wire logic rst_n,
    fsp_link_if.device link,
    input wire logic eepromBusy,
    input wire logic [7:0] fuseLowRaw,
    input wire logic [7:0] fuseHighRaw,
    input wire logic [2:0] fuseExtRaw,
    input wire logic [5:0] lockRaw
);
    logic [7:0] ctrlReg;
    logic [2:0] winReg;
    logic [22:0] timerReg;
    logic busyOpReg;
    logic rwwBusyReg;
    logic [15:0] pageBuf [WORDS];
    logic [15:0] flashMem [WORDS];
    logic armed;
    logic [7:0] loadDataReg;
    logic loadValidReg;
    logic eeReg;
    logic haltReg;
    logic onlyNrwwReg;

    assign armed = ctrlReg[FSP_BIT_LOCK_ARM] && ctrlReg[FSP_BIT_STORE_EN];
    assign link.ctrlRdata = {1'b0, rwwBusyReg, ctrlReg[5:0]};
    assign link.loadData = loadDataReg;
    assign link.loadValid = loadValidReg;
    assign link.eepromWriteBusyFlag = eeReg;
    assign link.cpuHalt = haltReg;
    assign link.nrwwReadOnly = onlyNrwwReg;

    always_ff @(posedge clk) begin
        eeReg <= eepromBusy;
    end

    // Arming window counter, restarted by each control write
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            winReg <= 3'h0;
        end else if (link.ctrlWe) begin
            winReg <= 3'h0;
        end else if (ctrlReg[FSP_BIT_STORE_EN] && !busyOpReg && winReg != 3'h7) begin
            winReg <= winReg + 3'h1;
        end
    end

    // Control/status register; a write in progress survives reset
    // Busy is tested first so an unknown busy at power-up falls into the reset branch
    always_ff @(posedge clk) begin
        if (busyOpReg) begin
            if (timerReg == 23'h1) begin
                ctrlReg[FSP_BIT_STORE_EN] <= 1'b0;
                ctrlReg[FSP_BIT_PAGE_ERASE] <= 1'b0;
                ctrlReg[FSP_BIT_PAGE_WRITE] <= 1'b0;
                ctrlReg[FSP_BIT_LOCK_ARM] <= 1'b0;
            end
        end else if (!rst_n) begin
            ctrlReg <= 8'h00;
        end else if (link.ctrlWe && !eeReg) begin
            ctrlReg[5:0] <= link.ctrlWdata[5:0];
        end else if (armed && link.loadStrobe && winReg < 3'(FSP_LOAD_WINDOW)) begin
            ctrlReg[FSP_BIT_STORE_EN] <= 1'b0;
            ctrlReg[FSP_BIT_LOCK_ARM] <= 1'b0;
        end else if (ctrlReg[FSP_BIT_STORE_EN] && link.storeStrobe && winReg < 3'(FSP_STORE_WINDOW)) begin
            if (!ctrlReg[FSP_BIT_PAGE_ERASE] && !ctrlReg[FSP_BIT_PAGE_WRITE]) begin
                ctrlReg <= {ctrlReg[7:6], 6'h00};
            end
        end else if (armed && winReg >= 3'(FSP_LOAD_WINDOW)) begin
            ctrlReg[FSP_BIT_STORE_EN] <= 1'b0;
            ctrlReg[FSP_BIT_LOCK_ARM] <= 1'b0;
        end else if (ctrlReg[FSP_BIT_STORE_EN] && winReg >= 3'(FSP_STORE_WINDOW)) begin
            ctrlReg[5:0] <= 6'h00;
        end
    end

    // Busy flag of the read-while-write section
    always_ff @(posedge clk) begin
        if (!rst_n && !busyOpReg) begin
            rwwBusyReg <= 1'b0;
        end else if (ctrlReg[FSP_BIT_STORE_EN] && link.storeStrobe && !busyOpReg
                     && winReg < 3'(FSP_STORE_WINDOW)
                     && (ctrlReg[FSP_BIT_PAGE_ERASE] || ctrlReg[FSP_BIT_PAGE_WRITE])) begin
            rwwBusyReg <= 1'b1;
        end else if (!busyOpReg && ctrlReg[FSP_BIT_STORE_EN] && ctrlReg[FSP_BIT_RWW_REEN]
                     && link.storeStrobe && winReg < 3'(FSP_STORE_WINDOW)) begin
            rwwBusyReg <= 1'b0;
        end
    end

    // Operation timer from the calibrated oscillator
    always_ff @(posedge clk) begin
        if (busyOpReg) begin
            timerReg <= timerReg - 23'h1;
            if (timerReg == 23'h1) begin
                busyOpReg <= 1'b0;
            end
        end else if (!rst_n) begin
            busyOpReg <= 1'b0;
            timerReg <= 23'h0;
        end else if (ctrlReg[FSP_BIT_STORE_EN] && link.storeStrobe && winReg < 3'(FSP_STORE_WINDOW)
                     && (ctrlReg[FSP_BIT_PAGE_ERASE] || ctrlReg[FSP_BIT_PAGE_WRITE])) begin
            busyOpReg <= 1'b1;
            timerReg <= 23'(PROG_CYCLES);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n && !busyOpReg) begin
            onlyNrwwReg <= 1'b0;
            haltReg <= 1'b0;
        end else begin
            onlyNrwwReg <= busyOpReg || rwwBusyReg;
            haltReg <= 1'b0;
        end
    end

    // Page buffer and flash array; buffer cleared by re-enable or by a reset outside an operation
    always_ff @(posedge clk) begin
        if (!rst_n && !busyOpReg) begin
            for (int i = 0; i < WORDS; i++) begin
                pageBuf[i] <= 16'hffff;
            end
        end else if (!busyOpReg && ctrlReg[FSP_BIT_STORE_EN] && link.storeStrobe
                     && winReg < 3'(FSP_STORE_WINDOW)) begin
            if (ctrlReg[5:0] == FSP_CMD_FILL[5:0]) begin
                pageBuf[link.pointer[6:1]] <= link.storeData;
            end else if (ctrlReg[FSP_BIT_RWW_REEN]) begin
                for (int i = 0; i < WORDS; i++) begin
                    pageBuf[i] <= 16'hffff;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (busyOpReg && timerReg == 23'h1) begin
            for (int i = 0; i < WORDS; i++) begin
                flashMem[i] <= ctrlReg[FSP_BIT_PAGE_ERASE] ? 16'hffff : (flashMem[i] & pageBuf[i]);
            end
        end
    end

    // Load answer, one cycle after the strobe
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            loadDataReg <= 8'h00;
            loadValidReg <= 1'b0;
        end else begin
            loadValidReg <= link.loadStrobe;
            if (link.loadStrobe) begin
                if (armed && winReg < 3'(FSP_LOAD_WINDOW) && !eeReg) begin
                    unique case (link.pointer)
                        FSP_PTR_LOCK: loadDataReg <= {2'b11, lockRaw};
                        FSP_PTR_FUSE_LOW: loadDataReg <= fuseLowRaw;
                        FSP_PTR_FUSE_HIGH: loadDataReg <= fuseHighRaw;
                        FSP_PTR_FUSE_EXT: loadDataReg <= {5'h1f, fuseExtRaw};
                        default: loadDataReg <= 8'hff;
                    endcase
                end else if (rwwBusyReg) begin
                    loadDataReg <= 8'hff;
                end else begin
                    loadDataReg <= link.pointer[0] ? flashMem[link.pointer[6:1]][15:8]
                                                   : flashMem[link.pointer[6:1]][7:0];
                end
            end
        end
    end
endmodule : fsp_device
`default_nettype wire

/* File: hdl/fsp_host.sv */
// CPU-side controller: Wishbone-commanded timed sequences toward the device
`timescale 1ns/1ns
`default_nettype none
module fsp_host
    import fsp_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    fsp_link_if.host link,
    input wire logic [5:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic wb_ack_o,
    output logic irq
);
    fsp_ctl_state_t stateReg;
    logic [7:0] cmdReg;
    logic [15:0] ptrReg;
    logic [15:0] dataReg;
    logic [7:0] resultReg;
    logic [1:0] irqStReg;
    logic [1:0] irqEnReg;
    logic isLoadReg;
    logic goReg;
    logic wbWr;
    logic opDone;
    logic readDone;
    logic ackReg;
    logic [31:0] datReg;
    logic irqReg;

    assign wbWr = wb_cyc_i && wb_stb_i && wb_we_i && !ackReg;
    assign opDone = stateReg == FSP_C_WAIT && !link.ctrlRdata[FSP_BIT_STORE_EN] && !isLoadReg;
    assign readDone = stateReg == FSP_C_WAIT && link.loadValid && isLoadReg;
    assign wb_ack_o = ackReg;
    assign wb_dat_o = datReg;
    assign irq = irqReg;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ackReg <= 1'b0;
            datReg <= 32'h0;
        end else begin
            ackReg <= wb_cyc_i && wb_stb_i && !ackReg;
            unique case (wb_adr_i)
                FSP_REG_COMMAND: datReg <= {24'h0, cmdReg};
                FSP_REG_POINTER: datReg <= {16'h0, ptrReg};
                FSP_REG_WDATA: datReg <= {16'h0, dataReg};
                FSP_REG_STATUS: datReg <= {24'h0, link.ctrlRdata[7:1], stateReg != FSP_C_IDLE};
                FSP_REG_IRQ_EN: datReg <= {30'h0, irqEnReg};
                FSP_REG_IRQ_ST: datReg <= {30'h0, irqStReg};
                FSP_REG_RESULT: datReg <= {24'h0, resultReg};
                default: datReg <= 32'h0;
            endcase
        end
    end

    // Register writes; a command write with bit 8 set requests a load
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cmdReg <= 8'h00;
            ptrReg <= 16'h0;
            dataReg <= 16'h0;
            irqEnReg <= 2'b00;
            isLoadReg <= 1'b0;
            goReg <= 1'b0;
        end else begin
            goReg <= 1'b0;
            if (wbWr && wb_sel_i[0]) begin
                unique case (wb_adr_i)
                    FSP_REG_COMMAND: begin
                        // A command while a sequence runs is ignored
                        if (stateReg == FSP_C_IDLE) begin
                            cmdReg <= wb_dat_i[7:0];
                            isLoadReg <= wb_dat_i[8];
                            goReg <= 1'b1;
                        end
                    end
                    FSP_REG_POINTER: ptrReg <= wb_dat_i[15:0];
                    FSP_REG_WDATA: dataReg <= wb_dat_i[15:0];
                    FSP_REG_IRQ_EN: irqEnReg <= wb_dat_i[1:0];
                    default: ;
                endcase
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irqStReg <= 2'b00;
            irqReg <= 1'b0;
        end else begin
            irqStReg <= (irqStReg & ~((wbWr && wb_adr_i == FSP_REG_IRQ_CL) ? wb_dat_i[1:0] : 2'b00))
                        | {readDone, opDone};
            irqReg <= |(irqStReg & irqEnReg);
        end
    end

    // Timed sequence: poll store enable and EEPROM, write control, strobe two cycles later
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stateReg <= FSP_C_IDLE;
            resultReg <= 8'h00;
            link.ctrlWe <= 1'b0;
            link.ctrlWdata <= 8'h00;
            link.loadStrobe <= 1'b0;
            link.storeStrobe <= 1'b0;
            link.pointer <= 16'h0;
            link.storeData <= 16'h0;
        end else begin
            link.ctrlWe <= 1'b0;
            link.loadStrobe <= 1'b0;
            link.storeStrobe <= 1'b0;
            unique case (stateReg)
                FSP_C_IDLE: if (goReg) stateReg <= FSP_C_POLL;
                FSP_C_POLL: begin
                    if (!link.ctrlRdata[FSP_BIT_STORE_EN] && !link.eepromWriteBusyFlag) begin
                        link.ctrlWe <= 1'b1;
                        link.ctrlWdata <= cmdReg;
                        link.pointer <= ptrReg;
                        link.storeData <= dataReg;
                        stateReg <= FSP_C_CTRL;
                    end
                end
                FSP_C_CTRL: stateReg <= FSP_C_OP;
                FSP_C_OP: begin
                    link.loadStrobe <= isLoadReg;
                    link.storeStrobe <= !isLoadReg;
                    stateReg <= FSP_C_WAIT;
                end
                FSP_C_WAIT: begin
                    if (readDone) begin
                        resultReg <= link.loadData;
                        stateReg <= FSP_C_IDLE;
                    end else if (opDone) begin
                        stateReg <= FSP_C_IDLE;
                    end
                end
                default: stateReg <= FSP_C_IDLE;
            endcase
        end
    end
endmodule : fsp_host
`default_nettype wire

/* File: sim/fsp_link_sva.sv */
// Assertions on the link between the self-programming device and its controller
`timescale 1ns/1ns
`default_nettype none
module fsp_link_sva
    import fsp_pkg::*;
#(
    parameter int PROG_CYCLES = FSP_PROG_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ctrlWe,
    input wire logic [7:0] ctrlWdata,
    input wire logic [7:0] ctrlRdata,
    input wire logic loadStrobe,
    input wire logic storeStrobe,
    input wire logic [15:0] pointer,
    input wire logic [7:0] loadData,
    input wire logic loadValid,
    input wire logic eepromWriteBusyFlag,
    input wire logic nrwwReadOnly,
    input wire logic [7:0] fuseLowRaw,
    input wire logic [7:0] fuseHighRaw,
    input wire logic [2:0] fuseExtRaw,
    input wire logic [5:0] lockRaw
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic opBit;
    int opCnt = 0;
    logic reenSeen = 1'b0;
    assign opBit = ctrlRdata[FSP_BIT_STORE_EN] & (ctrlRdata[FSP_BIT_PAGE_ERASE] | ctrlRdata[FSP_BIT_PAGE_WRITE]);
    // Keeps counting through a reset, since a running operation survives it
    always_ff @(posedge clk) begin
        opCnt <= (opBit || (!rst_n && opCnt != 0)) ? opCnt + 1 : 0;
    end
    always_ff @(posedge clk) begin
        if (ctrlWe && ctrlWdata[FSP_BIT_RWW_REEN]) begin
            reenSeen <= 1'b1;
        end else if ($rose(ctrlRdata[FSP_BIT_RWW_BUSY])) begin
            reenSeen <= 1'b0;
        end
    end
    sequence armedAt(logic [15:0] p);
        loadStrobe && ctrlRdata[FSP_BIT_LOCK_ARM] && ctrlRdata[FSP_BIT_STORE_EN] && pointer == p;
    endsequence
    sequence armedLoad;
        loadStrobe && ctrlRdata[FSP_BIT_LOCK_ARM] && ctrlRdata[FSP_BIT_STORE_EN];
    endsequence
    chk_load_answer: assert property (loadStrobe |=> loadValid) else $error("load without answer");
    chk_lock_value: assert property (armedAt(FSP_PTR_LOCK) |=> loadData[5:0] == lockRaw)
        else $error("lock readback wrong");
    chk_fuse_low: assert property (armedAt(FSP_PTR_FUSE_LOW) |=> loadData == fuseLowRaw)
        else $error("low fuse readback wrong");
    chk_fuse_high: assert property (armedAt(FSP_PTR_FUSE_HIGH) |=> loadData == fuseHighRaw)
        else $error("high fuse readback wrong");
    chk_fuse_ext: assert property (armedAt(FSP_PTR_FUSE_EXT) |=> loadData[2:0] == fuseExtRaw)
        else $error("extended fuse readback wrong");
    chk_arm_clear: assert property (armedLoad |=> ##[0:1] !ctrlRdata[FSP_BIT_LOCK_ARM] && !ctrlRdata[0])
        else $error("arming bits not cleared");
    chk_busy_time: assert property ($fell(opBit) |-> opCnt >= PROG_CYCLES - 1 && opCnt <= PROG_CYCLES + 2)
        else $error("operation length off");
    chk_no_read_while_write_section_only: assert property (opBit [*4] |-> nrwwReadOnly) else $error("section open during op");
    chk_rww_hold: assert property ($fell(ctrlRdata[FSP_BIT_RWW_BUSY]) |-> reenSeen)
        else $error("busy flag cleared without re-enable");
    chk_ee_idle: assert property (ctrlWe |-> !eepromWriteBusyFlag) else $error("control write during eeprom");
    chk_poll_idle: assert property (ctrlWe |-> !ctrlRdata[FSP_BIT_STORE_EN]) else $error("control write busy");
    chk_store_window: assert property (ctrlWe |-> ##[1:4] (loadStrobe || storeStrobe))
        else $error("no strobe after control write");
endmodule : fsp_link_sva
`default_nettype wire

/* File: sim/fuse_lock_readback_and_self_program_test.sv */
// Self-checking bench for the self-programming device and controller pair
`timescale 1ns/1ns
`default_nettype none
module fuse_lock_readback_and_self_program_test
    import fsp_pkg::*;
;
    localparam int PROG = 20;
    logic clk, rst_n, wbWe, wbCyc, wbStb, wbAck, irq, eepromBusy;
    logic [5:0] wbAdr;
    logic [31:0] wbDat, wbRdat, q;
    logic [3:0] wbSel;
    logic [7:0] fuseLowRaw, fuseHighRaw;
    logic [2:0] fuseExtRaw;
    logic [5:0] lockRaw;
    logic [31:0] rnd;
    logic [7:0] fuseExp[4];
    logic [7:0] fuseMask[4] = '{8'hff, 8'h3f, 8'h07, 8'hff};
    int flashMem[8];
    int miscompares = 0;
    int checksDone = 0;
    fsp_link_if link();
    fsp_device #(.PROG_CYCLES(PROG)) i_fsp_device (.clk(clk), .rst_n(rst_n), .link(link), .eepromBusy(eepromBusy),
        .fuseLowRaw(fuseLowRaw), .fuseHighRaw(fuseHighRaw), .fuseExtRaw(fuseExtRaw), .lockRaw(lockRaw));
    fsp_host i_fsp_host (.clk(clk), .rst_n(rst_n), .link(link), .wb_adr_i(wbAdr), .wb_dat_i(wbDat),
        .wb_dat_o(wbRdat), .wb_we_i(wbWe), .wb_sel_i(wbSel), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
        .wb_ack_o(wbAck), .irq(irq));
    fsp_link_sva #(.PROG_CYCLES(PROG)) chkLink (.clk(clk), .rst_n(rst_n), .ctrlWe(link.ctrlWe),
        .ctrlWdata(link.ctrlWdata), .ctrlRdata(link.ctrlRdata), .loadStrobe(link.loadStrobe),
        .storeStrobe(link.storeStrobe), .pointer(link.pointer), .loadData(link.loadData), .loadValid(link.loadValid),
        .eepromWriteBusyFlag(link.eepromWriteBusyFlag), .nrwwReadOnly(link.nrwwReadOnly), .fuseLowRaw(fuseLowRaw),
        .fuseHighRaw(fuseHighRaw), .fuseExtRaw(fuseExtRaw), .lockRaw(lockRaw));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs
    task automatic printVerdict;
        $display("checks %0d mismatches %0d", checksDone, miscompares);
        if (miscompares == 0 && checksDone > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : printVerdict
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checksDone++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic wbCycle(input logic [5:0] a, input logic [31:0] d, input logic w, output logic [31:0] r);
        int n;
        n = 0;
        wbAdr <= a;
        wbDat <= d;
        wbWe <= w;
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (wbAck !== 1'b1 && n < 50);
        if (wbAck !== 1'b1) begin
            miscompares++;
            $display("[ERR] %0t bus timeout ack %h expected %h", $time, wbAck, 1'b1);
        end
        r = wbRdat;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        @(posedge clk);
    endtask : wbCycle
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] r;
        wbCycle(a, d, 1'b1, r);
    endtask : wr
    task automatic waitIdle;
        logic [31:0] s;
        int n;
        n = 0;
        s = 32'h1;
        while (s[0] !== 1'b0 && n < 60) begin
            wbCycle(FSP_REG_STATUS, 32'h0, 1'b0, s);
            n++;
        end
        if (s[0] !== 1'b0) begin
            miscompares++;
            $display("[ERR] %0t idle timeout busy %h expected %h", $time, s[0], 1'b0);
        end
    endtask : waitIdle
    task automatic runCmd(input logic [8:0] cmd, input logic [15:0] ptr, input logic [15:0] wd);
        wr(FSP_REG_POINTER, {16'h0, ptr});
        wr(FSP_REG_WDATA, {16'h0, wd});
        wr(FSP_REG_COMMAND, {23'h0, cmd});
        waitIdle();
    endtask : runCmd
    task automatic pageCycle(input bit midReset);
        runCmd({1'b0, FSP_CMD_ERASE}, 16'h0000, 16'h0000);
        wbCycle(FSP_REG_STATUS, 32'h0, 1'b0, q);
        check({31'h0, q[6]}, 32'h1);
        runCmd({1'b0, FSP_CMD_REENABLE}, 16'h0000, 16'h0000);
        wbCycle(FSP_REG_STATUS, 32'h0, 1'b0, q);
        check({31'h0, q[6]}, 32'h0);
        for (int i = 0; i < 4; i++) begin
            rnd = xs(rnd);
            flashMem[2 * i] = rnd[7:0];
            flashMem[2 * i + 1] = rnd[15:8];
            runCmd({1'b0, FSP_CMD_FILL}, 16'(2 * i), rnd[15:0]);
        end
        wr(FSP_REG_POINTER, 32'h0);
        wr(FSP_REG_COMMAND, {24'h0, FSP_CMD_WRITE});
        if (midReset) begin
            repeat (5) @(posedge clk);
            rst_n <= 1'b0;
            repeat (2) @(posedge clk);
            rst_n <= 1'b1;
            repeat (PROG + 10) @(posedge clk);
        end
        waitIdle();
        runCmd({1'b0, FSP_CMD_REENABLE}, 16'h0000, 16'h0000);
        for (int b = 0; b < 8; b++) begin
            runCmd(9'h100, 16'(b), 16'h0000);
            wbCycle(FSP_REG_RESULT, 32'h0, 1'b0, q);
            check({24'h0, q[7:0]}, 32'(flashMem[b]));
        end
    endtask : pageCycle
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        printVerdict();
    end
    initial begin
        rnd = 32'ha7e2;
        rst_n <= 1'b0;
        {wbWe, wbCyc, wbStb, eepromBusy} <= 4'h0;
        wbAdr <= 6'h00;
        wbDat <= 32'h0;
        wbSel <= 4'hf;
        rnd = xs(rnd);
        {fuseLowRaw, fuseHighRaw, fuseExtRaw, lockRaw} <= rnd[24:0];
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        fuseExp = '{fuseLowRaw, {2'b11, lockRaw}, {5'h1f, fuseExtRaw}, fuseHighRaw};
        for (int p = 0; p < 4; p++) begin
            runCmd({1'b1, FSP_CMD_LOCK_READ}, 16'(p), 16'h0000);
            wbCycle(FSP_REG_RESULT, 32'h0, 1'b0, q);
            check({24'h0, q[7:0] & fuseMask[p]}, {24'h0, fuseExp[p] & fuseMask[p]});
            wbCycle(FSP_REG_STATUS, 32'h0, 1'b0, q);
            check({30'h0, q[3], link.ctrlRdata[FSP_BIT_STORE_EN]}, 32'h0);
        end
        // Interrupt raised, cleared, then masked
        wr(FSP_REG_IRQ_EN, 32'h2);
        runCmd({1'b1, FSP_CMD_LOCK_READ}, FSP_PTR_LOCK, 16'h0000);
        repeat (2) @(posedge clk);
        check({31'h0, irq}, 32'h1);
        wr(FSP_REG_IRQ_CL, 32'h2);
        repeat (2) @(posedge clk);
        check({31'h0, irq}, 32'h0);
        wr(FSP_REG_IRQ_EN, 32'h0);
        runCmd({1'b1, FSP_CMD_LOCK_READ}, FSP_PTR_FUSE_LOW, 16'h0000);
        wbCycle(FSP_REG_IRQ_ST, 32'h0, 1'b0, q);
        check({31'h0, q[1]}, 32'h1);
        check({31'h0, irq}, 32'h0);
        pageCycle(1'b0);
        // Command held back while the eeprom is writing
        eepromBusy <= 1'b1;
        repeat (3) @(posedge clk);
        wr(FSP_REG_POINTER, {16'h0, FSP_PTR_FUSE_HIGH});
        wr(FSP_REG_COMMAND, {23'h0, 1'b1, FSP_CMD_LOCK_READ});
        repeat (10) @(posedge clk);
        wbCycle(FSP_REG_STATUS, 32'h0, 1'b0, q);
        check({31'h0, q[0]}, 32'h1);
        eepromBusy <= 1'b0;
        waitIdle();
        wbCycle(FSP_REG_RESULT, 32'h0, 1'b0, q);
        check({24'h0, q[7:0]}, {24'h0, fuseHighRaw});
        pageCycle(1'b1);
        printVerdict();
    end
endmodule : fuse_lock_readback_and_self_program_test
`default_nettype wire
